// ===== rtl/mcp_pin_if.sv
// Purpose: Pin-level sequencer of the memory controller: chip selects, lane strobes,
//          SDRAM command lines, buffer and latch controls, programmed pattern lines.
// Assumes: Requests and inputs are synchronous to clock_i; one access at a time.
`timescale 1ns/1ns
module mcp_pin_if
  import mcp_pkg::*;
(
  input  wire logic                  clock_i,
  input  wire logic                  reset_i,
  input  wire mcp_pkg::mcp_req_t     req_i,
  input  wire mcp_pkg::mcp_cfg_t     cfg_i,
  input  wire mcp_pkg::mcp_pat_word_t pat_prog_i [mcp_pkg::PAT_WORDS],
  input  wire logic                  simple_machine_ack_in_n_i,
  input  wire logic                  pattern_machine_wait_in_i,
  output mcp_pkg::mcp_pins_t         pins_o,
  output logic                       ready_o,
  output logic                       done_o
);
  import mcp_pkg::*;

  mcp_st_t       q;
  mcp_st_t       d;
  mcp_pat_word_t word;
  logic          start;
  logic [7:0]    req_lanes;

  // Lanes touched by an access: size-wide span at the address offset within the port.
  function automatic logic [7:0] lane_mask(input logic [2:0] a, input logic [1:0] sz,
                                           input logic [1:0] pl);
    logic [7:0] span;
    logic [7:0] port;
    logic [3:0] pmask;
    logic [2:0] off;
    span  = ALL_LANES >> (FULL_W4 - (ONE_W4 << sz));
    port  = ALL_LANES >> (FULL_W4 - (ONE_W4 << pl));
    pmask = (ONE_W4 << pl) - ONE_W4;
    off   = a & pmask[2:0];
    return (span << off) & port;
  endfunction : lane_mask

  assign start     = (q.fsm == ST_IDLE) && req_i.valid;
  assign req_lanes = lane_mask(req_i.addr[2:0], req_i.size_log, req_i.port_log);
  assign word      = pat_prog_i[q.idx];

  always_comb
  begin
    d      = q;
    d.done = 1'b0;
    unique case (q.fsm)
      ST_IDLE:
      begin
        if (req_i.valid)
        begin
          d.ready    = 1'b0;
          d.write    = req_i.write;
          d.auto_pre = req_i.auto_pre;
          d.lanes    = req_lanes;
          d.cnt      = '0;
          d.idx      = '0;
          d.pins.cs_n = ~(BANK0_SEL << req_i.bank);
          d.pins.ale  = cfg_i.ext_master;
          d.pins.burst_addr_lines = req_i.addr[BADDR_HI:BADDR_LO];
          d.pins.parity_chip_select_n = ~cfg_i.parity_en;
          d.pins.buffer_ctrl_b = (cfg_i.buffer_ctrl_function_field == BCTL_MODE_RW) ?
                                 ~req_i.write : 1'b0;
          d.pins.buffer_ctrl_a = (cfg_i.buffer_ctrl_function_field == BCTL_MODE_RW) ?
                                 req_i.write : ~req_i.write;
          if (req_i.machine == MACH_SCS)
          begin
            d.fsm = ST_SCS;
            d.pins.memory_output_enable_n = req_i.write;
            d.pins.write_lane_strobes_n = req_i.write ? ~req_lanes : ALL_LANES;
          end
          else if (req_i.machine == MACH_SDRAM)
          begin
            d.fsm = ST_SDACT;
            d.pins.sdram_row_strobe_n  = 1'b0;
            d.pins.sdram_addr_ten      = req_i.addr[ROW_A10_BIT];
            d.pins.sdram_addr_mux_ctrl = 1'b0;
          end
          else
          begin
            d.fsm = ST_PAT;
          end
        end
      end
      ST_SCS:
      begin
        d.pins.ale = 1'b0;
        d.cnt      = q.cnt + 4'h1;
        if (cfg_i.ext_term ? !simple_machine_ack_in_n_i : (q.cnt == SCS_LAST))
        begin
          d.pins  = PINS_IDLE;
          d.done  = 1'b1;
          d.ready = 1'b1;
          d.fsm   = ST_IDLE;
        end
      end
      ST_SDACT:
      begin
        d.pins.ale                   = 1'b0;
        d.pins.sdram_row_strobe_n    = 1'b1;
        d.pins.sdram_column_strobe_n = 1'b0;
        d.pins.sdram_write_strobe_n  = ~q.write;
        d.pins.sdram_addr_ten        = q.auto_pre;
        d.pins.sdram_addr_mux_ctrl   = 1'b1;
        d.pins.sdram_lane_masks      = ~q.lanes;
        d.fsm                        = ST_SDCMD;
      end
      ST_SDCMD:
      begin
        d.pins  = PINS_IDLE;
        d.done  = 1'b1;
        d.ready = 1'b1;
        d.fsm   = ST_IDLE;
      end
      ST_PAT:
      begin
        d.pins.ale = 1'b0;
        d.pins.pattern_lines = word.gpl;
        d.pins.programmed_lane_selects_n = word.lanes_on ? ~q.lanes : ALL_LANES;
        if (word.addr_inc)
        begin
          d.pins.burst_addr_lines = q.pins.burst_addr_lines + 2'h1;
        end
        if (!(word.wait_chk && pattern_machine_wait_in_i))
        begin
          if (word.last || (q.idx == PAT_LAST_IDX))
          begin
            d.fsm = ST_PATEND;
          end
          else
          begin
            d.idx = q.idx + 3'h1;
          end
        end
      end
      ST_PATEND:
      begin
        d.pins  = PINS_IDLE;
        d.done  = 1'b1;
        d.ready = 1'b1;
        d.fsm   = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_i)
  begin
    if (reset_i)
    begin
      q <= ST_RESET;
    end
    else
    begin
      q <= d;
    end
  end

  assign pins_o  = q.pins;
  assign ready_o = q.ready;
  assign done_o  = q.done;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (reset_i);

  sequence s_sd_row;
    !pins_o.sdram_row_strobe_n && !pins_o.sdram_addr_mux_ctrl;
  endsequence
  sequence s_sd_col;
    !pins_o.sdram_column_strobe_n && pins_o.sdram_row_strobe_n && pins_o.sdram_addr_mux_ctrl;
  endsequence

  chk_reset_idle_pins: assert property (disable iff (1'b0) reset_i |=> pins_o == PINS_IDLE)
    else $error("outputs not idle after reset");
  chk_bank_select: assert property (start |=> pins_o.cs_n == ~(BANK0_SEL << $past(req_i.bank)))
    else $error("wrong bank select");
  chk_buffer_ctrl: assert property (start |=> pins_o.buffer_ctrl_a != pins_o.buffer_ctrl_b
      || !pins_o.buffer_ctrl_b) else $error("buffer controls inconsistent");
  chk_burst_addr: assert property (start |=> pins_o.burst_addr_lines ==
      $past(req_i.addr[BADDR_HI:BADDR_LO])) else $error("burst address not loaded");
  chk_ale_pulse: assert property (start && cfg_i.ext_master |=> pins_o.ale ##1 !pins_o.ale)
    else $error("latch strobe not a one cycle pulse");
  chk_scs_write: assert property (start && req_i.write && req_i.machine == MACH_SCS
      |=> pins_o.write_lane_strobes_n == ~$past(req_lanes)) else $error("write strobes wrong");
  chk_sd_masks: assert property (q.fsm == ST_SDACT |=> pins_o.sdram_lane_masks == ~q.lanes)
    else $error("lane masks wrong");
  chk_pat_lanes: assert property (q.fsm == ST_PAT && word.lanes_on
      |=> pins_o.programmed_lane_selects_n == ~q.lanes) else $error("lane selects wrong");
  chk_sd_a10_row: assert property (start && req_i.machine == MACH_SDRAM
      |=> pins_o.sdram_addr_ten == $past(req_i.addr[ROW_A10_BIT])) else $error("row a10 wrong");
  chk_pat_lines: assert property (q.fsm == ST_PAT
      |=> pins_o.pattern_lines == $past(word.gpl)) else $error("pattern lines wrong");
  chk_sd_sequence: assert property (start && req_i.machine == MACH_SDRAM
      |=> s_sd_row ##1 s_sd_col ##1 done_o) else $error("sdram command order wrong");
  chk_scs_read_oe: assert property (start && !req_i.write && req_i.machine == MACH_SCS
      |=> !pins_o.memory_output_enable_n) else $error("output enable missing");
  chk_scs_ack_end: assert property (q.fsm == ST_SCS && cfg_i.ext_term
      && !simple_machine_ack_in_n_i |=> done_o && pins_o.cs_n == ALL_LANES)
    else $error("access not ended on acknowledge");
  chk_pat_wait_hold: assert property (q.fsm == ST_PAT && word.wait_chk
      && pattern_machine_wait_in_i |=> q.fsm == ST_PAT && $stable(q.idx))
    else $error("pattern machine ran through wait");
  chk_parity_select: assert property (start && cfg_i.parity_en
      |=> !pins_o.parity_chip_select_n) else $error("parity select missing");
  chk_amux_col: assert property (q.fsm == ST_SDACT |=> pins_o.sdram_addr_mux_ctrl
      ##1 !pins_o.sdram_addr_mux_ctrl) else $error("address mux control wrong");
endmodule : mcp_pin_if

// ===== rtl/mcp_pkg.sv
// Purpose: Constants and types for the memory controller pin interface.
// Assumes: 50 MHz bus clock, one access in flight at a time.
// Notes:   Pin fields ending in _n are active low; masks are active high.
package mcp_pkg;
  localparam int CLK_PERIOD_NS = 20;
  localparam int SCS_HOLD_NS   = 60;
  localparam int SCS_HOLD_CYC  = (SCS_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W         = 4;
  localparam int PAT_WORDS     = 8;
  localparam int PAT_IDX_W     = 3;
  localparam int LANES         = 8;
  localparam int BANK_W        = 3;
  localparam int GPL_W         = 6;
  localparam int ROW_A10_BIT   = 10;
  localparam int BADDR_HI      = 4;
  localparam int BADDR_LO      = 3;

  localparam logic [PAT_IDX_W-1:0] PAT_LAST_IDX = 3'h7;
  localparam logic [CNT_W-1:0]     SCS_LAST     = 4'(SCS_HOLD_CYC - 1);
  localparam logic [LANES-1:0]     ALL_LANES    = 8'hff;
  localparam logic [LANES-1:0]     BANK0_SEL    = 8'h01;
  localparam logic [3:0]           ONE_W4       = 4'h1;
  localparam logic [3:0]           FULL_W4      = 4'h8;

  // Buffer control modes: direction plus enable, or separate read and write enables.
  localparam logic [1:0] BCTL_MODE_DIR = 2'h0;
  localparam logic [1:0] BCTL_MODE_RW  = 2'h1;

  localparam logic [1:0] MACH_SCS   = 2'h0;
  localparam logic [1:0] MACH_SDRAM = 2'h1;

  typedef enum logic [5:0] {
    ST_IDLE   = 6'h01,
    ST_SCS    = 6'h02,
    ST_SDACT  = 6'h04,
    ST_SDCMD  = 6'h08,
    ST_PAT    = 6'h10,
    ST_PATEND = 6'h20
  } mcp_state_t;

  typedef struct packed {
    logic              valid;
    logic              write;
    logic [BANK_W-1:0] bank;
    logic [1:0]        machine;
    logic [31:0]       addr;
    logic [1:0]        size_log;
    logic [1:0]        port_log;
    logic              auto_pre;
  } mcp_req_t;

  typedef struct packed {
    logic [1:0] buffer_ctrl_function_field;
    logic       ext_master;
    logic       ext_term;
    logic       parity_en;
  } mcp_cfg_t;

  typedef struct packed {
    logic [GPL_W-1:0] gpl;
    logic             lanes_on;
    logic             wait_chk;
    logic             addr_inc;
    logic             last;
  } mcp_pat_word_t;

  typedef struct packed {
    logic [LANES-1:0] cs_n;
    logic             buffer_ctrl_a;
    logic             buffer_ctrl_b;
    logic [1:0]       burst_addr_lines;
    logic             ale;
    logic [LANES-1:0] write_lane_strobes_n;
    logic [LANES-1:0] sdram_lane_masks;
    logic [LANES-1:0] programmed_lane_selects_n;
    logic             sdram_addr_ten;
    logic [GPL_W-1:0] pattern_lines;
    logic             sdram_write_strobe_n;
    logic             sdram_row_strobe_n;
    logic             sdram_column_strobe_n;
    logic             memory_output_enable_n;
    logic             parity_chip_select_n;
    logic             sdram_addr_mux_ctrl;
  } mcp_pins_t;

  localparam mcp_pins_t PINS_IDLE = '{
    cs_n: 8'hff, buffer_ctrl_a: 1'b1, buffer_ctrl_b: 1'b1, burst_addr_lines: 2'h0,
    ale: 1'b0, write_lane_strobes_n: 8'hff, sdram_lane_masks: 8'hff,
    programmed_lane_selects_n: 8'hff, sdram_addr_ten: 1'b0, pattern_lines: 6'h3f,
    sdram_write_strobe_n: 1'b1, sdram_row_strobe_n: 1'b1, sdram_column_strobe_n: 1'b1,
    memory_output_enable_n: 1'b1, parity_chip_select_n: 1'b1, sdram_addr_mux_ctrl: 1'b0};

  typedef struct packed {
    mcp_state_t           fsm;
    mcp_pins_t            pins;
    logic [CNT_W-1:0]     cnt;
    logic [PAT_IDX_W-1:0] idx;
    logic                 write;
    logic                 auto_pre;
    logic [LANES-1:0]     lanes;
    logic                 ready;
    logic                 done;
  } mcp_st_t;

  localparam mcp_st_t ST_RESET = '{
    fsm: ST_IDLE, pins: PINS_IDLE, cnt: 4'h0, idx: 3'h0, write: 1'b0,
    auto_pre: 1'b0, lanes: 8'h00, ready: 1'b1, done: 1'b0};
endpackage : mcp_pkg

// ===== dv/mcp_mem_model.sv
// Purpose: Memory device model facing the pin sequencer.
// Assumes: The bench sets acknowledge delay and wait length.
// Notes:   Counts cycles since a bank select went active.
`timescale 1ns/1ns
module mcp_mem_model (
  input  wire logic       clock_i,
  input  wire logic       reset_i,
  input  wire logic [7:0] cs_n_i,
  input  wire logic [3:0] ack_dly_i,
  input  wire logic [3:0] wait_len_i,
  output logic            ack_n_o,
  output logic            wait_o
);
  logic [3:0] cnt_q;
  logic       sel;
  assign sel = ~&cs_n_i;
  always_ff @(posedge clock_i)
  begin
    if (reset_i || !sel)
      cnt_q <= 4'h0;
    else if (cnt_q != 4'hf)
      cnt_q <= cnt_q + 4'h1;
  end
  // One acknowledge pulse, held low once the count saturates if ack_dly_i is 15; pulled up otherwise.
  assign ack_n_o = !(sel && cnt_q == ack_dly_i);
  assign wait_o = sel && cnt_q < wait_len_i;
endmodule : mcp_mem_model

// ===== dv/testbench.sv
// Purpose: Self-checking bench for the memory controller pin sequencer.
// Assumes: 50 MHz clock, synchronous active-high reset.
// Notes:   Each scenario follows one access cycle by cycle.
`timescale 1ns/1ns
module testbench;
  import mcp_pkg::*;
  logic          clock_i = 1'b0;
  logic          reset_i = 1'b1;
  mcp_req_t      req;
  mcp_cfg_t      cfg;
  mcp_pat_word_t prog [PAT_WORDS];
  mcp_pins_t     pins;
  logic          ready;
  logic          done;
  logic          ack_n;
  logic          wt;
  logic [3:0]    ack_dly;
  logic [3:0]    wait_len;
  int            errors = 0;
  int            comparisons = 0;

  always #10 clock_i = ~clock_i;

  mcp_pin_if mcp_pin_if_inst (.clock_i(clock_i), .reset_i(reset_i), .req_i(req),
    .cfg_i(cfg), .pat_prog_i(prog), .simple_machine_ack_in_n_i(ack_n),
    .pattern_machine_wait_in_i(wt), .pins_o(pins), .ready_o(ready), .done_o(done));
  mcp_mem_model mcp_mem_model_inst (.clock_i(clock_i), .reset_i(reset_i),
    .cs_n_i(pins.cs_n), .ack_dly_i(ack_dly), .wait_len_i(wait_len), .ack_n_o(ack_n),
    .wait_o(wt));

  task automatic wrap_up();
    if (errors == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : wrap_up

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (exp !== got)
    begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic chk_pins(input string what, input mcp_pins_t exp, input mcp_pins_t got);
    comparisons++;
    if (exp !== got)
    begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_pins

  task automatic step();
    @(posedge clock_i);
    #1;
  endtask : step

  task automatic issue(input mcp_req_t r, input mcp_cfg_t c, input logic [3:0] ad,
                       input logic [3:0] wl);
    @(posedge clock_i);
    req      <= r;
    cfg      <= c;
    ack_dly  <= ad;
    wait_len <= wl;
    // Valid drops at the taking edge, so the next step sees the first access cycle.
    fork
      begin
        @(posedge clock_i);
        req.valid <= 1'b0;
      end
    join_none
  endtask : issue

  function automatic mcp_req_t mk(logic w, logic [2:0] b, logic [1:0] m, logic [31:0] a,
                                  logic [1:0] s, logic [1:0] p, logic ap);
    mk = '{valid: 1'b1, write: w, bank: b, machine: m, addr: a, size_log: s,
           port_log: p, auto_pre: ap};
  endfunction : mk

  task automatic finish_access();
    step();
    chk("done", 1'b1, done);
    chk("ready", 1'b1, ready);
    chk_pins("idle pins", PINS_IDLE, pins);
  endtask : finish_access

  task automatic t_simple_read();
    issue(mk(1'b0, 3'h5, MACH_SCS, 32'h0, 2'h3, 2'h3, 1'b0), 5'b00101, 4'h0, 4'h0);
    for (int c = 1; c <= 3; c++)
    begin
      step();
      chk("cs_n", 8'hdf, pins.cs_n);
      chk("oe_n", 1'b0, pins.memory_output_enable_n);
      chk("parity_n", 1'b0, pins.parity_chip_select_n);
      chk("buf_a", 1'b1, pins.buffer_ctrl_a);
      chk("buf_b", 1'b0, pins.buffer_ctrl_b);
      chk("ale", 32'(c == 1), pins.ale);
      chk("done", 1'b0, done);
    end
    finish_access();
  endtask : t_simple_read

  task automatic t_simple_write();
    issue(mk(1'b1, 3'h2, MACH_SCS, 32'h13, 2'h0, 2'h1, 1'b0), 5'b01000, 4'h9, 4'h0);
    for (int c = 1; c <= 3; c++)
    begin
      step();
      chk("cs_n", 8'hfb, pins.cs_n);
      chk("we_n", 8'hfd, pins.write_lane_strobes_n);
      chk("oe_n", 1'b1, pins.memory_output_enable_n);
      chk("burst", 2'h2, pins.burst_addr_lines);
      chk("buf_a", 1'b1, pins.buffer_ctrl_a);
      chk("buf_b", 1'b0, pins.buffer_ctrl_b);
      chk("parity_n", 1'b1, pins.parity_chip_select_n);
      chk("ale", 1'b0, pins.ale);
    end
    finish_access();
  endtask : t_simple_write

  task automatic t_ext_term();
    issue(mk(1'b0, 3'h0, MACH_SCS, 32'h0, 2'h3, 2'h3, 1'b0), 5'b00010, 4'h3, 4'h0);
    for (int c = 1; c <= 4; c++)
    begin
      step();
      chk("cs_n", 8'hfe, pins.cs_n);
      chk("done", 1'b0, done);
    end
    finish_access();
  endtask : t_ext_term

  task automatic t_sdram(input logic w, input logic ap, input logic [31:0] a);
    issue(mk(w, 3'h1, MACH_SDRAM, a, 2'h1, 2'h3, ap), 5'b00100, 4'h9, 4'h0);
    step();
    chk("ras_n", 1'b0, pins.sdram_row_strobe_n);
    chk("cas_n", 1'b1, pins.sdram_column_strobe_n);
    chk("a10 row", a[10], pins.sdram_addr_ten);
    chk("amux row", 1'b0, pins.sdram_addr_mux_ctrl);
    step();
    chk("ras_n", 1'b1, pins.sdram_row_strobe_n);
    chk("cas_n", 1'b0, pins.sdram_column_strobe_n);
    chk("we_n", !w, pins.sdram_write_strobe_n);
    chk("a10 col", ap, pins.sdram_addr_ten);
    chk("amux col", 1'b1, pins.sdram_addr_mux_ctrl);
    chk("masks", 8'hcf, pins.sdram_lane_masks);
    finish_access();
  endtask : t_sdram

  task automatic t_pattern(input logic [3:0] wl, input int exp_hi);
    int n1;
    int hi;
    n1 = 0;
    hi = 0;
    issue(mk(1'b0, 3'h3, 2'h2, 32'h0c, 2'h2, 2'h3, 1'b0), 5'b00000, 4'h9, wl);
    step();
    chk("cs_n", 8'hf7, pins.cs_n);
    step();
    chk("gpl", 6'h15, pins.pattern_lines);
    chk("sel_n", 8'h0f, pins.programmed_lane_selects_n);
    hi = int'(wt);
    step();
    while (pins.pattern_lines === 6'h2a && n1 < 12)
    begin
      n1++;
      hi += int'(wt);
      chk("sel_n", 8'hff, pins.programmed_lane_selects_n);
      step();
    end
    chk("repeats", exp_hi + 1, n1);
    chk("stalls", exp_hi, hi);
    chk("gpl", 6'h0c, pins.pattern_lines);
    chk("burst", 2'h2, pins.burst_addr_lines);
    finish_access();
  endtask : t_pattern

  // Cuts a hang short.
  initial
  begin
    #20000;
    errors++;
    wrap_up();
  end

  initial
  begin
    req      = '0;
    cfg      = '0;
    ack_dly  = 4'h0;
    wait_len = 4'h0;
    for (int i = 0; i < PAT_WORDS; i++)
      prog[i] = {6'h3f, 4'b0001};
    prog[0] = {6'h15, 4'b1000};
    prog[1] = {6'h2a, 4'b0110};
    prog[2] = {6'h0c, 4'b1001};
    repeat (5) @(posedge clock_i);
    #1;
    chk_pins("reset pins", PINS_IDLE, pins);
    chk("reset ready", 1'b1, ready);
    chk("reset done", 1'b0, done);
    @(posedge clock_i);
    reset_i <= 1'b0;
    t_simple_read();
    t_simple_write();
    t_ext_term();
    t_sdram(1'b0, 1'b0, 32'h404);
    t_sdram(1'b1, 1'b1, 32'h004);
    t_pattern(4'h0, 0);
    t_pattern(4'h5, 4);
    wrap_up();
  end
endmodule : testbench
